// >>> core/usb_top_control.sv
// USB top control: line status, packet hold, role, reset/resume drive, table base
//
// Summary of operation
// [RULE_01] Control bit 7 shows live J state seen by the receiver.
// [RULE_02] Control bit 6 shows live single-ended zero on the lines.
// [RULE_03] Function role: bit 5 holds packet processing; set on SETUP, cleared by software.
// [RULE_04] Host role: bit 5 reads high while a token is executing.
// [RULE_05] Host software checks token busy clear before writing a new token.
// [RULE_06] Host role: bit 4 drives bus reset while set.
// [RULE_07] Bit 3 enables host capability.
// [RULE_08] Any change of host enable resets all host control logic.
// [RULE_09] Bit 2 drives resume signalling while set.
// [RULE_10] Software holds resume 10 ms as function, 25 ms as host.
// [RULE_11] Host role: clearing resume appends a low-speed end of packet.
// [RULE_12] Page two register holds table base bits 23 to 16.
// [RULE_13] Page three register holds table base bits 31 to 24.
// [RULE_14] Table base is always 512-byte aligned.
// [RULE_15] Page one supplies bits 15 to 9; all pages combine into base.
// [RULE_16] Bit 0 enables module or frame start; bit 1 resets ping-pong pointers.
`timescale 1ns/1ns
`default_nettype none
module usb_top_control (
    // Clock and reset
    input  wire logic                        mclk,
    input  wire logic                        srst,
    // Register port
    input  wire logic [7:0]                  reg_addr,
    input  wire logic [31:0]                 reg_wdata,
    input  wire logic                        reg_write,
    input  wire logic                        reg_read,
    output logic      [31:0]                 reg_rdata,
    // Line status and token engine
    input  wire usb_ctl_pkg::line_status_t   line_status,
    input  wire usb_ctl_pkg::token_event_t   token_event,
    // Controls toward the protocol engine
    output logic                             module_enable,
    output logic                             sof_enable,
    output logic                             pingpong_reset,
    output logic                             packet_hold,
    output logic                             host_logic_reset,
    output logic                             token_start,
    output logic      [7:0]                  token_command,
    output usb_ctl_pkg::line_drive_t         line_drive,
    output logic      [31:0]                 table_base,
    // Interrupt
    output logic                             irq
);
    // Software control bits, token state and edge history
    logic       packet_processing_hold;
    logic       bus_reset_drive;
    logic       host_role_enable;
    logic       resume_drive;
    logic       pingpong_pointer_reset;
    logic       module_enable_function;
    logic [6:0] table_base_bits_15_9;
    logic [7:0] table_base_bits_23_16;
    logic [7:0] table_base_bits_31_24;
    logic [usb_ctl_pkg::IRQ_WIDTH-1:0] irq_mask;
    logic [7:0] token_command_reg;
    logic       token_in_progress;
    logic       host_en_prev;
    logic       resume_prev;

    logic       next_packet_processing_hold;
    logic       next_bus_reset_drive;
    logic       next_host_role_enable;
    logic       next_resume_drive;
    logic       next_pingpong_pointer_reset;
    logic       next_module_enable_function;
    logic [6:0] next_table_base_bits_15_9;
    logic [7:0] next_table_base_bits_23_16;
    logic [7:0] next_table_base_bits_31_24;
    logic [usb_ctl_pkg::IRQ_WIDTH-1:0] next_irq_mask;
    logic [7:0] next_token_command_reg;
    logic       next_token_in_progress;
    logic       next_token_start;
    logic [31:0] next_reg_rdata;

    // Output flops
    logic       next_host_logic_reset;
    usb_ctl_pkg::line_drive_t next_line_drive;
    logic [31:0] next_table_base;

    // Sub-block wiring
    logic [usb_ctl_pkg::IRQ_WIDTH-1:0] irq_status;
    logic [usb_ctl_pkg::IRQ_WIDTH-1:0] irq_events;
    logic [usb_ctl_pkg::IRQ_WIDTH-1:0] irq_clear;
    logic       irq_line;
    usb_ctl_pkg::line_drive_t eop_drive;
    logic       eop_busy;
    logic       eop_done;
    logic       eop_start;
    logic       host_toggle;

    function automatic logic hit(input logic [7:0] off);
        hit = (reg_addr == off);
    endfunction

    function automatic logic [7:0] control_view(input logic host);
        control_view = {line_status.j_state, // RULE_01
                        line_status.se0, // RULE_02
                        host ? token_in_progress : packet_processing_hold, // RULE_04
                        bus_reset_drive, host_role_enable, resume_drive,
                        pingpong_pointer_reset, module_enable_function};
    endfunction

    logic wr_ctl;
    logic wr_tok;
    assign wr_ctl = reg_write && hit(usb_ctl_pkg::OFF_CONTROL);
    assign wr_tok = reg_write && hit(usb_ctl_pkg::OFF_TOKEN_CMD);

    // Host enable change, in either direction
    assign host_toggle = host_role_enable != host_en_prev;                   // RULE_08
    // Resume fall in host role starts the EOP
    assign eop_start   = resume_prev && !resume_drive && host_role_enable;   // RULE_11

    always_comb begin
        next_packet_processing_hold  = packet_processing_hold;
        next_bus_reset_drive         = bus_reset_drive;
        next_host_role_enable        = host_role_enable;
        next_resume_drive            = resume_drive;
        next_pingpong_pointer_reset  = pingpong_pointer_reset;
        next_module_enable_function  = module_enable_function;
        next_table_base_bits_15_9    = table_base_bits_15_9;
        next_table_base_bits_23_16   = table_base_bits_23_16;
        next_table_base_bits_31_24   = table_base_bits_31_24;
        next_irq_mask                = irq_mask;
        next_token_command_reg       = token_command_reg;
        next_token_in_progress       = token_in_progress;
        next_token_start             = 1'b0;
        irq_clear                    = '0;

        if (wr_ctl) begin
            {next_packet_processing_hold, next_bus_reset_drive, next_host_role_enable,
             next_resume_drive, next_pingpong_pointer_reset,
             next_module_enable_function} = reg_wdata[5:0]; // RULE_07 RULE_09
        end
        if (reg_write && hit(usb_ctl_pkg::OFF_PAGE_ONE)) begin
            next_table_base_bits_15_9 = reg_wdata[7:1];                          // RULE_15
        end
        if (reg_write && hit(usb_ctl_pkg::OFF_PAGE_TWO)) begin
            next_table_base_bits_23_16 = reg_wdata[7:0];                         // RULE_12
        end
        if (reg_write && hit(usb_ctl_pkg::OFF_PAGE_THREE)) begin
            next_table_base_bits_31_24 = reg_wdata[7:0];                         // RULE_13
        end
        if (reg_write && hit(usb_ctl_pkg::OFF_IRQ_MASK)) begin
            next_irq_mask = reg_wdata[usb_ctl_pkg::IRQ_WIDTH-1:0];
        end
        if (reg_write && hit(usb_ctl_pkg::OFF_IRQ_STATUS)) begin
            irq_clear = reg_wdata[usb_ctl_pkg::IRQ_WIDTH-1:0];
        end

        // Token busy only tracked in host role
        if (host_role_enable && wr_tok) begin
            next_token_command_reg = reg_wdata[7:0];
            next_token_in_progress = 1'b1;                                       // RULE_04
            next_token_start       = 1'b1;
        end
        if (token_event.token_done) begin
            next_token_in_progress = 1'b0;
        end

        // SETUP sets hold; set wins over clear
        if (!host_role_enable && token_event.setup_seen) begin
            next_packet_processing_hold = 1'b1;                                  // RULE_03
        end

        // Host state dropped on role change
        if (host_toggle) begin
            next_token_in_progress = 1'b0;                                       // RULE_08
            next_token_command_reg = 8'h00;
            next_bus_reset_drive   = 1'b0;
        end
    end

    always_comb begin
        next_host_logic_reset = host_toggle;                                     // RULE_08
        // Priority: bus reset, then resume K, then trailing EOP
        if (host_role_enable && bus_reset_drive) begin
            next_line_drive = usb_ctl_pkg::DRIVE_SE0;                            // RULE_06
        end else if (resume_drive) begin
            next_line_drive = usb_ctl_pkg::DRIVE_K;                              // RULE_09
        end else if (eop_busy) begin
            next_line_drive = eop_drive;                                         // RULE_11
        end else begin
            next_line_drive = usb_ctl_pkg::DRIVE_IDLE;
        end
        // Low bits below the boundary are always zero
        next_table_base = {table_base_bits_31_24, table_base_bits_23_16,
                           table_base_bits_15_9, {usb_ctl_pkg::ALIGN_BITS{1'b0}}}; // RULE_14

        next_reg_rdata = 32'h0000_0000;
        if (reg_read) begin
            if (hit(usb_ctl_pkg::OFF_CONTROL)) begin
                next_reg_rdata[7:0] = control_view(host_role_enable);
            end else if (hit(usb_ctl_pkg::OFF_PAGE_ONE)) begin
                next_reg_rdata[7:1] = table_base_bits_15_9;
            end else if (hit(usb_ctl_pkg::OFF_PAGE_TWO)) begin
                next_reg_rdata[7:0] = table_base_bits_23_16;
            end else if (hit(usb_ctl_pkg::OFF_PAGE_THREE)) begin
                next_reg_rdata[7:0] = table_base_bits_31_24;
            end else if (hit(usb_ctl_pkg::OFF_IRQ_STATUS)) begin
                next_reg_rdata[usb_ctl_pkg::IRQ_WIDTH-1:0] = irq_status;
            end else if (hit(usb_ctl_pkg::OFF_IRQ_MASK)) begin
                next_reg_rdata[usb_ctl_pkg::IRQ_WIDTH-1:0] = irq_mask;
            end else if (hit(usb_ctl_pkg::OFF_TOKEN_CMD)) begin
                next_reg_rdata[7:0] = token_command_reg;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            {packet_processing_hold, bus_reset_drive, host_role_enable, resume_drive,
             pingpong_pointer_reset, module_enable_function} <= usb_ctl_pkg::RST_CONTROL[5:0];
            table_base_bits_15_9   <= usb_ctl_pkg::RST_PAGE[7:1];
            table_base_bits_23_16  <= usb_ctl_pkg::RST_PAGE;
            table_base_bits_31_24  <= usb_ctl_pkg::RST_PAGE;
            irq_mask               <= '0;
            token_command_reg      <= 8'h00;
            token_in_progress      <= 1'b0;
            host_en_prev           <= 1'b0;
            resume_prev            <= 1'b0;
            token_start            <= 1'b0;
            token_command          <= 8'h00;
            host_logic_reset       <= 1'b0;
            line_drive             <= usb_ctl_pkg::DRIVE_IDLE;
            table_base             <= 32'h0000_0000;
            reg_rdata              <= 32'h0000_0000;
        end else begin
            packet_processing_hold <= next_packet_processing_hold;
            bus_reset_drive        <= next_bus_reset_drive;
            host_role_enable       <= next_host_role_enable;
            resume_drive           <= next_resume_drive;
            pingpong_pointer_reset <= next_pingpong_pointer_reset;
            module_enable_function <= next_module_enable_function;
            table_base_bits_15_9   <= next_table_base_bits_15_9;
            table_base_bits_23_16  <= next_table_base_bits_23_16;
            table_base_bits_31_24  <= next_table_base_bits_31_24;
            irq_mask               <= next_irq_mask;
            token_command_reg      <= next_token_command_reg;
            token_in_progress      <= next_token_in_progress;
            host_en_prev           <= host_role_enable;
            resume_prev            <= resume_drive;
            token_start            <= next_token_start;
            token_command          <= next_token_command_reg;
            host_logic_reset       <= next_host_logic_reset;
            line_drive             <= next_line_drive;
            table_base             <= next_table_base;
            reg_rdata              <= next_reg_rdata;
        end
    end

    // Role outputs
    always_ff @(posedge mclk) begin
        if (srst) begin
            module_enable  <= 1'b0;
            sof_enable     <= 1'b0;
            pingpong_reset <= 1'b0;
            packet_hold    <= 1'b0;
        end else begin
            module_enable  <= module_enable_function && !next_host_role_enable;  // RULE_16
            sof_enable     <= module_enable_function && next_host_role_enable;   // RULE_16
            pingpong_reset <= next_pingpong_pointer_reset;                        // RULE_16
            packet_hold    <= next_packet_processing_hold && !next_host_role_enable; // RULE_03
        end
    end

    assign irq_events = {eop_done, host_toggle, token_event.token_done,
                         !host_role_enable && token_event.setup_seen};

    usb_irq_bank u_irq (
        .mclk       (mclk),
        .srst       (srst),
        .events     (irq_events),
        .clear_bits (irq_clear),
        .mask       (irq_mask),
        .status     (irq_status),
        .irq        (irq_line)
    );

    usb_eop_shaper u_eop (
        .mclk  (mclk),
        .srst  (srst || host_toggle),
        .start (eop_start),
        .drive (eop_drive),
        .busy  (eop_busy),
        .done  (eop_done)
    );

    assign irq = irq_line;
endmodule
`default_nettype wire

// >>> core/usb_ctl_pkg.sv
// Register map, fields, timing and carriers of the USB top control
package usb_ctl_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CONTROL     = 8'h00;
    localparam logic [7:0] OFF_PAGE_ONE    = 8'h04;
    localparam logic [7:0] OFF_PAGE_TWO    = 8'h08;
    localparam logic [7:0] OFF_PAGE_THREE  = 8'h0c;
    localparam logic [7:0] OFF_IRQ_STATUS  = 8'h10;
    localparam logic [7:0] OFF_IRQ_MASK    = 8'h14;
    localparam logic [7:0] OFF_TOKEN_CMD   = 8'h18;

    // Control register bit positions
    localparam int BIT_J_LINE      = 7;
    localparam int BIT_SE0         = 6;
    localparam int BIT_PKT_HOLD    = 5;
    localparam int BIT_BUS_RESET   = 4;
    localparam int BIT_HOST_EN     = 3;
    localparam int BIT_RESUME      = 2;
    localparam int BIT_PP_RESET    = 1;
    localparam int BIT_MODULE_EN   = 0;

    // Interrupt status bit positions
    localparam int IRQ_SETUP       = 0;
    localparam int IRQ_TOKEN_DONE  = 1;
    localparam int IRQ_HOST_TOGGLE = 2;
    localparam int IRQ_EOP_DONE    = 3;
    localparam int IRQ_WIDTH       = 4;

    // Page one holds bits 15:9 in its bits 7:1; alignment is 512 bytes
    localparam int ALIGN_BITS      = 9;

    // Reset values
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_PAGE    = 8'h00;

    // Low-speed end of packet: two bit times of SE0 then one of J, at 1.5 Mbit/s
    localparam int EOP_BIT_NS      = 667;
    localparam int CLK_NS          = 40;
    localparam int EOP_BIT_CYCLES  = (EOP_BIT_NS + CLK_NS - 1) / CLK_NS;
    localparam int EOP_SE0_BITS    = 2;
    localparam int EOP_J_BITS      = 1;

    // Line drive request toward the transceiver
    typedef enum logic [1:0] {
        DRIVE_IDLE,
        DRIVE_SE0,
        DRIVE_K,
        DRIVE_J
    } line_drive_t;

    // Live line status from the receiver
    typedef struct packed {
        logic j_state;
        logic se0;
    } line_status_t;

    // Token engine handshake
    typedef struct packed {
        logic setup_seen;
        logic token_done;
    } token_event_t;
endpackage

// >>> core/usb_eop_shaper.sv
// Low-speed end-of-packet sequencer appended after host resume
`timescale 1ns/1ns
`default_nettype none
module usb_eop_shaper (
    // Clock and reset
    input  wire logic                      mclk,
    input  wire logic                      srst,
    // Control
    input  wire logic                      start,
    // Result
    output usb_ctl_pkg::line_drive_t       drive,
    output logic                           busy,
    output logic                           done
);
    typedef enum logic [1:0] {ST_IDLE, ST_SE0, ST_J} eop_state_t;

    eop_state_t state;
    eop_state_t next_state;
    logic [7:0] count;
    logic [7:0] next_count;
    logic       next_done;

    localparam logic [7:0] SE0_LEN =
        8'(usb_ctl_pkg::EOP_BIT_CYCLES * usb_ctl_pkg::EOP_SE0_BITS);
    localparam logic [7:0] J_LEN =
        8'(usb_ctl_pkg::EOP_BIT_CYCLES * usb_ctl_pkg::EOP_J_BITS);

    always_comb begin
        next_state = state;
        next_count = count;
        next_done  = 1'b0;
        unique case (state)
            ST_IDLE: begin
                if (start) begin
                    next_state = ST_SE0;
                    next_count = SE0_LEN - 8'h01;
                end
            end
            ST_SE0: begin
                if (count == 8'h00) begin
                    next_state = ST_J;
                    next_count = J_LEN - 8'h01;
                end else begin
                    next_count = count - 8'h01;
                end
            end
            ST_J: begin
                if (count == 8'h00) begin
                    next_state = ST_IDLE;
                    next_done  = 1'b1;
                end else begin
                    next_count = count - 8'h01;
                end
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            state <= ST_IDLE;
            count <= 8'h00;
            done  <= 1'b0;
        end else begin
            state <= next_state;
            count <= next_count;
            done  <= next_done;
        end
    end

    assign busy  = (state != ST_IDLE);
    assign drive = (state == ST_SE0) ? usb_ctl_pkg::DRIVE_SE0 :
                   (state == ST_J)   ? usb_ctl_pkg::DRIVE_J : usb_ctl_pkg::DRIVE_IDLE;
endmodule
`default_nettype wire

// >>> core/usb_irq_bank.sv
// Sticky event flags, write-one-to-clear, with mask and level interrupt
`timescale 1ns/1ns
`default_nettype none
module usb_irq_bank (
    // Clock and reset
    input  wire logic                             mclk,
    input  wire logic                             srst,
    // Events and software access
    input  wire logic [usb_ctl_pkg::IRQ_WIDTH-1:0] events,
    input  wire logic [usb_ctl_pkg::IRQ_WIDTH-1:0] clear_bits,
    input  wire logic [usb_ctl_pkg::IRQ_WIDTH-1:0] mask,
    // Result
    output logic      [usb_ctl_pkg::IRQ_WIDTH-1:0] status,
    output logic                                   irq
);
    logic [usb_ctl_pkg::IRQ_WIDTH-1:0] next_status;
    logic                              next_irq;

    always_comb begin
        // Set wins over a clear in the same cycle
        next_status = (status & ~clear_bits) | events;
        next_irq    = |(next_status & mask);
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            status <= '0;
            irq    <= 1'b0;
        end else begin
            status <= next_status;
            irq    <= next_irq;
        end
    end
endmodule
`default_nettype wire

// >>> verification/usb_top_control_asserts.sv
// Checker for the USB top control ports
`timescale 1ns/1ns
`default_nettype none
module usb_top_control_asserts (
    // Clock, reset, register port
    input wire logic                      mclk,
    input wire logic                      srst,
    input wire logic [7:0]                reg_addr,
    input wire logic                      reg_write,
    input wire logic                      reg_read,
    input wire logic [31:0]               reg_rdata,
    // Events and controls
    input wire usb_ctl_pkg::token_event_t token_event,
    input wire logic                      module_enable,
    input wire logic                      sof_enable,
    input wire logic                      pingpong_reset,
    input wire logic                      packet_hold,
    input wire logic                      host_logic_reset,
    input wire logic                      token_start,
    input wire logic [31:0]               table_base
);
    wire logic tok_wr = reg_write && reg_addr == usb_ctl_pkg::OFF_TOKEN_CMD;
    wire logic ctl_wr = reg_write && reg_addr == usb_ctl_pkg::OFF_CONTROL;
    logic [3:0] ctl_hist;
    // Recent control writes
    always_ff @(posedge mclk) begin
        ctl_hist <= srst ? 4'h0 : {ctl_hist[2:0], ctl_wr};
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    base_align_a: assert property (table_base[8:0] == 9'h0)
        else $error("table base not aligned");
    base_write_a: assert property ($changed(table_base) |-> $past(reg_write) || $past(reg_write, 2))
        else $error("table base moved without a write");
    rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
        else $error("read data outside read cycle");
    rdata_upper_a: assert property ($past(reg_read) |-> reg_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    hold_cause_a: assert property ($rose(packet_hold) |-> $past(token_event.setup_seen) || $past(reg_write))
        else $error("hold rose without setup");
    token_cause_a: assert property (token_start |-> $past(tok_wr) || $past(tok_wr, 2))
        else $error("token start without token write");
    role_excl_a: assert property (module_enable |-> !sof_enable)
        else $error("both role enables high");
    host_pulse_a: assert property (host_logic_reset |=> !host_logic_reset)
        else $error("host reset pulse too long");
    host_cause_a: assert property (host_logic_reset |-> |ctl_hist)
        else $error("host reset without control write");
    pp_cause_a: assert property ($changed(pingpong_reset) |-> |ctl_hist[1:0])
        else $error("pointer reset moved without write");
endmodule
bind usb_top_control usb_top_control_asserts chk_u (.mclk(mclk), .srst(srst), .reg_addr(reg_addr),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .token_event(token_event),
    .module_enable(module_enable), .sof_enable(sof_enable), .pingpong_reset(pingpong_reset),
    .packet_hold(packet_hold), .host_logic_reset(host_logic_reset), .token_start(token_start),
    .table_base(table_base));
`default_nettype wire

// >>> verification/usb_bus_partner.sv
// Bus-side partner: line levels and token engine events
`timescale 1ns/1ns
`default_nettype none
module usb_bus_partner #(
    parameter int DONE_DELAY = 8
) (
    // Clock, reset, requests
    input  wire logic                     mclk,
    input  wire logic                     srst,
    input  wire usb_ctl_pkg::line_drive_t line_drive,
    input  wire logic                     token_start,
    input  wire logic                     force_se0,
    input  wire logic                     setup_req,
    // Toward the block
    output usb_ctl_pkg::line_status_t     line_status,
    output usb_ctl_pkg::token_event_t     token_event
);
    int cnt;
    // Idle bus is pulled to J
    always_comb begin
        line_status.se0     = force_se0 || line_drive == usb_ctl_pkg::DRIVE_SE0;
        line_status.j_state = !line_status.se0 && line_drive != usb_ctl_pkg::DRIVE_K;
    end
    always_ff @(posedge mclk) begin
        token_event.setup_seen <= setup_req && !srst;
        token_event.token_done <= cnt == 1;
        if (srst) cnt <= 0;
        else if (token_start) cnt <= DONE_DELAY;
        else if (cnt > 0) cnt <= cnt - 1;
    end
endmodule
`default_nettype wire

// >>> verification/usb_top_control_tb.sv
// Self-checking bench for the USB top control
`timescale 1ns/1ns
`default_nettype none
module usb_top_control_tb;
    localparam logic [7:0] CT = usb_ctl_pkg::OFF_CONTROL;
    localparam logic [7:0] P2 = usb_ctl_pkg::OFF_PAGE_TWO;
    localparam logic [7:0] P3 = usb_ctl_pkg::OFF_PAGE_THREE;
    logic                      mclk, srst, reg_write, reg_read, force_se0, setup_req;
    logic                      module_enable, sof_enable, pingpong_reset, packet_hold;
    logic                      host_logic_reset, token_start, irq;
    logic [7:0]                reg_addr, tc;
    logic [31:0]               reg_wdata, reg_rdata, table_base, s;
    usb_ctl_pkg::line_status_t line_status;
    usb_ctl_pkg::token_event_t token_event;
    usb_ctl_pkg::line_drive_t  line_drive;
    int                        n_errors, n_compared, hl, i;
    usb_top_control dut_u (.mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .line_status(line_status), .token_event(token_event), .module_enable(module_enable),
        .sof_enable(sof_enable), .pingpong_reset(pingpong_reset), .packet_hold(packet_hold),
        .host_logic_reset(host_logic_reset), .token_start(token_start), .token_command(tc),
        .line_drive(line_drive), .table_base(table_base), .irq(irq));
    usb_bus_partner far_u (.mclk(mclk), .srst(srst), .line_drive(line_drive),
        .token_start(token_start), .force_se0(force_se0), .setup_req(setup_req),
        .line_status(line_status), .token_event(token_event));
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic print_verdict;
        if (n_errors == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        {reg_addr, reg_wdata, reg_write} <= {a, d, 1'b1};
        @(posedge mclk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk);
        {reg_addr, reg_read} <= {a, 1'b1};
        @(posedge mclk);
        reg_read <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    task automatic setup;
        @(posedge mclk) setup_req <= 1'b1;
        @(posedge mclk) setup_req <= 1'b0;
    endtask
    task automatic drv(input int n, input usb_ctl_pkg::line_drive_t v);
        wt(n);
        chk(32'(line_drive), 32'(v));
    endtask
    task automatic role(input logic [31:0] v);
        wr(CT, v);
        hl = 0;
        repeat (5) begin
            @(posedge mclk);
            #1 if (host_logic_reset === 1'b1) hl++;
        end
        chk(hl, 1);
        chk(32'({sof_enable, module_enable}), v[3] ? 32'h2 : 32'h1);
    endtask
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    initial begin
        repeat (3000) @(posedge mclk);
        n_errors++;
        print_verdict();
    end
    initial begin
        {srst, reg_write, reg_read, force_se0, setup_req, reg_addr, reg_wdata} = '0;
        srst = 1'b1;
        s = 32'h74c8;
        repeat (10) @(posedge mclk);
        srst <= 1'b0;
        rd(CT, 32'h80);
        force_se0 <= 1'b1;
        rd(CT, 32'h40);
        force_se0 <= 1'b0;
        for (i = 0; i < 4; i++) begin
            s = lfsr(s);
            wr(usb_ctl_pkg::OFF_PAGE_ONE, s);
            wr(P2, s >> 8);
            wr(P3, s >> 16);
            rd(P2, {24'h0, s[15:8]});
            rd(P3, {24'h0, s[23:16]});
            chk(table_base, {s[23:16], s[15:8], s[7:1], 9'h0});
        end
        wr(8'h1c, 32'hff);
        rd(8'h1c, 32'h0);
        wr(usb_ctl_pkg::OFF_IRQ_MASK, 32'h1);
        wr(CT, 32'h1);
        setup();
        wt(3);
        chk(32'({packet_hold, irq, module_enable}), 32'h7);
        rd(CT, 32'ha1);
        rd(usb_ctl_pkg::OFF_IRQ_STATUS, 32'h1);
        wr(usb_ctl_pkg::OFF_IRQ_STATUS, 32'h1);
        wr(CT, 32'h1);
        wt(3);
        chk(32'({packet_hold, irq}), 32'h0);
        wr(usb_ctl_pkg::OFF_IRQ_MASK, 32'h0);
        setup();
        wt(3);
        chk(32'({packet_hold, irq}), 32'h2);
        wr(CT, 32'h5);
        drv(3, usb_ctl_pkg::DRIVE_K);
        wr(CT, 32'h1);
        drv(3, usb_ctl_pkg::DRIVE_IDLE);
        role(32'h9);
        setup();
        rd(CT, 32'h89);
        wr(usb_ctl_pkg::OFF_TOKEN_CMD, 32'h5d);
        rd(CT, 32'ha9);
        chk(tc, 32'h5d);
        wt(12);
        rd(CT, 32'h89);
        wr(CT, 32'h19);
        drv(3, usb_ctl_pkg::DRIVE_SE0);
        rd(CT, 32'h59);
        wr(CT, 32'hd);
        drv(3, usb_ctl_pkg::DRIVE_K);
        wr(CT, 32'h9);
        drv(20, usb_ctl_pkg::DRIVE_SE0);
        drv(20, usb_ctl_pkg::DRIVE_J);
        drv(20, usb_ctl_pkg::DRIVE_IDLE);
        role(32'h1);
        wr(CT, 32'h2);
        wt(3);
        chk(32'({tc, pingpong_reset}), 32'h1);
        srst <= 1'b1;
        wt(2);
        srst <= 1'b0;
        rd(P3, 32'h0);
        chk(table_base, 32'h0);
        print_verdict();
    end
endmodule
`default_nettype wire
